// ### aptr_pkg.sv
// package of constants and types for the phase tracking receiver
package aptr_pkg;

    // =====================================================================
    // datapath widths
    // =====================================================================
    localparam int SLICE_W = 4;
    localparam int TX_SLICE_W = 8;
    localparam int WORD_W = 10;
    localparam int GEAR_W = 15;
    localparam int TAP_W = 9;
    localparam int NBITS_W = 3;
    localparam int XBITS_W = 5;

    // =====================================================================
    // register interface of the slice controller
    // =====================================================================
    localparam int REGIF_ADDR_W = 6;
    localparam int REGIF_DATA_W = 16;
    localparam int REGIF_NIB_W = 2;
    localparam logic [5:0] BIT_TIME_ADDR = 6'h2c;
    localparam logic [1:0] BIT_TIME_NIBBLE = 2'h0;
    localparam int READ_WAIT_MAX = 64;

    // =====================================================================
    // reset values and tracking constants
    // =====================================================================
    localparam logic [8:0] TAP_RESET = 9'h000;
    localparam int VOTE_W = 8;
    localparam int VOTE_LIMIT = 16;
    localparam logic [3:0] GEAR_EMIT_FILL = 4'ha;
    localparam logic [2:0] PUSH_NORMAL = 3'h4;
    localparam logic [2:0] PUSH_DROP = 3'h3;
    localparam logic [2:0] PUSH_INSERT = 3'h5;

    // =====================================================================
    // line figures
    // =====================================================================
    localparam int LINE_RATE_MBPS = 1250;
    localparam int LINE_RATE_MAX_MBPS = 1300;
    localparam int WORD_RATE_KHZ = LINE_RATE_MBPS * 1000 / SLICE_W;
    localparam int SLIP_TOL_PPM = 200;

    typedef enum logic [1:0] {
        ST_WAIT_RDY = 2'b00,
        ST_READ = 2'b01,
        ST_LOAD = 2'b11,
        ST_TRACK = 2'b10
    } aptr_state_type;

endpackage : aptr_pkg

// ### aptr_gear_if.sv
// interface carrying bit groups from the tracker into the gearbox
`timescale 1ns/10ps
interface aptr_gear_if;
    logic push;
    logic [2:0] nbits;
    logic [4:0] bits;
    modport src (output push, output nbits, output bits);
    modport sink (input push, input nbits, input bits);
endinterface : aptr_gear_if

// ### aptr_gearbox.sv
// gearbox: 15-bit shift register with a two-entry output buffer
`timescale 1ns/10ps
module aptr_gearbox
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // bit groups from the tracker
    aptr_gear_if.sink gear,
    // word stream
    output logic [9:0] word_data,
    output logic word_valid,
    input wire logic word_ready,
    output logic overflow
);

    typedef struct packed {
        logic [14:0] sr;
        logic [3:0] cnt;
        logic [9:0] e0;
        logic [9:0] e1;
        logic v0;
        logic v1;
        logic ovf;
    } aptr_gear_state_type;

    aptr_gear_state_type q;
    aptr_gear_state_type next_q;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb
    begin
        logic emit;
        logic pop;
        logic [3:0] rem;
        logic [9:0] word;
        next_q = q;
        pop = q.v0 && word_ready;
        // a word leaves the shift register only while the buffer has room
        emit = (q.cnt >= aptr_pkg::GEAR_EMIT_FILL) && !q.v1; // R6
        word = 10'(q.sr >> 4'(q.cnt - aptr_pkg::GEAR_EMIT_FILL));
        rem = emit ? 4'(q.cnt - aptr_pkg::GEAR_EMIT_FILL) : q.cnt;
        next_q.cnt = rem;
        if (gear.push)
        begin
            if (({1'b0, rem} + {2'b00, gear.nbits}) > 5'h0f)
                next_q.ovf = 1'b1;
            else
            begin
                // 3, 4 or 5 bits enter so a slip drops or inserts one bit
                next_q.sr = 15'((q.sr << gear.nbits) | {10'h000, gear.bits}); // R7
                next_q.cnt = 4'(rem + {1'b0, gear.nbits}); // R7
            end
        end
        if (pop)
        begin
            next_q.e0 = q.e1;
            next_q.v0 = q.v1;
            next_q.v1 = 1'b0;
        end
        if (emit)
        begin
            if (!next_q.v0)
            begin
                next_q.e0 = word;
                next_q.v0 = 1'b1;
            end
            else
            begin
                next_q.e1 = word;
                next_q.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            q <= '0;
        else
            q <= next_q;
    end

    assign word_data = q.e0;
    assign word_valid = q.v0;
    assign overflow = q.ovf;

    // =====================================================================
    // checks
    // =====================================================================
    property p_hold_word;
        @(posedge mclk) disable iff (reset)
        (q.v0 && !word_ready) |=> (q.v0 && $stable(q.e0));
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("word lost under stall"); // R6

    property p_emit_fill;
        @(posedge mclk) disable iff (reset)
        (q.cnt >= 4'ha && !q.v1 && !gear.push) |=> (q.cnt == $past(q.cnt) - 4'ha);
    endproperty
    a_emit_fill: assert property (p_emit_fill) else $error("gearbox did not emit ten bits"); // R6

    property p_fill_count;
        @(posedge mclk) disable iff (reset)
        (gear.push && q.cnt < 4'ha && !q.ovf) |=> (q.cnt == $past(q.cnt) + 4'($past(gear.nbits)));
    endproperty
    a_fill_count: assert property (p_fill_count) else $error("gearbox fill count wrong"); // R7

endmodule : aptr_gearbox

// ### aptr_receiver.sv
// phase tracking receiver: bit time read, bang-bang tracker and gearbox
//
// Summary of operation
// (R1) each pair uses two slices: active at bit centre, monitor at bit edge
// (R2) bang-bang compare of active and monitor samples steps the monitor delay
// (R3) active delay stays monitor delay plus half the bit time in taps
// (R4) before tracking, read the bit time tap count and store it
// (R5) phase moves by loading delays; larger delay samples earlier
// (R6) gearbox turns 4-bit groups into 10-bit words, losing none unless a stalled sink lets it overflow
// (R7) gearbox is a 15-bit shift register inserting or dropping one bit
// (R8) bit insertion and removal covers up to 200 ppm rate offset
// (R9) gearbox write and read sides share the one word-rate clock
// (R10) receive slices run asynchronous mode, 4-bit words; transmit uses 8
// (R11) far transmitter sends at most 1300 Mb/s, matched within tracking range
// (R12) register master drives 6-bit address, 16-bit write data, write enable
// (R13) slice controller answers 16-bit read data with a valid strobe
// (R14) register master drives a 2-bit nibble select
// (R15) shared byte group: read data of both controllers is OR-combined
// (R16) one measured bit time serves every receive channel
// (R17) no phase adjustment before bit time is read and delays are ready
`timescale 1ns/10ps
module aptr_receiver
#(
    parameter int VOTE_LIMIT = aptr_pkg::VOTE_LIMIT,
    parameter int READ_WAIT_MAX = aptr_pkg::READ_WAIT_MAX
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // receive slices of one differential pair
    input wire logic [3:0] active_bits,
    input wire logic [3:0] monitor_bits,
    input wire logic delay_ready,
    output logic active_load,
    output logic [8:0] active_delay,
    output logic monitor_load,
    output logic [8:0] monitor_delay,
    // register interface toward the slice controller
    output logic [5:0] regif_address,
    output logic [15:0] regif_write_data,
    output logic regif_write_enable,
    output logic [1:0] regif_nibble_select,
    input wire logic [15:0] regif_read_data,
    input wire logic regif_read_valid,
    input wire logic [15:0] regif_read_data_tx,
    input wire logic regif_read_valid_tx,
    // status
    output logic [8:0] bit_time_taps,
    output logic tracking,
    output logic gear_overflow,
    // recovered 10-bit words
    output logic [9:0] word_data,
    output logic word_valid,
    input wire logic word_ready
);

    typedef struct packed {
        aptr_pkg::aptr_state_type st;
        logic [5:0] regif_address;
        logic [15:0] regif_write_data;
        logic regif_write_enable;
        logic [1:0] regif_nibble_select;
        logic [7:0] wait_cnt;
        logic [8:0] bit_time_taps;
        logic [8:0] mon_delay;
        logic [8:0] act_delay;
        logic mon_load;
        logic act_load;
        logic signed [7:0] vote;
        logic gear_push;
        logic [2:0] gear_nbits;
        logic [4:0] gear_bits;
        logic tracking;
    } aptr_rx_state_type;

    aptr_rx_state_type q;
    aptr_rx_state_type next_q;

    aptr_gear_if gear ();

    // =====================================================================
    // helpers
    // =====================================================================
    // each data transition inside the 4-bit group votes on which side of the edge the monitor sat
    function automatic logic signed [2:0] aptr_vote(input logic [3:0] a, input logic [3:0] m);
        logic signed [2:0] v;
        v = 3'sd0;
        for (int j = 3; j >= 1; j--)
        begin
            if (a[j] != a[j - 1])
            begin
                if (m[j] == a[j])
                    v = v - 3'sd1;
                else
                    v = v + 3'sd1;
            end
        end
        return v;
    endfunction : aptr_vote

    function automatic logic [8:0] aptr_centre(input logic [8:0] mon, input logic [8:0] taps);
        return 9'(mon + {1'b0, taps[8:1]});
    endfunction : aptr_centre

    // =====================================================================
    // read data from both controllers of a shared byte group
    // =====================================================================
    logic [15:0] rd_data;
    logic rd_valid;
    logic signed [2:0] step_vote;
    logic signed [7:0] vote_sum;

    assign rd_data = regif_read_data | regif_read_data_tx; // R15
    assign rd_valid = regif_read_valid | regif_read_valid_tx; // R15 R13
    assign step_vote = aptr_vote(active_bits, monitor_bits); // R1 R2
    assign vote_sum = 8'(q.vote + 8'(step_vote));

    // =====================================================================
    // sequencer: wait ready, read bit time, load, track
    // =====================================================================
    always_comb
    begin
        next_q = q;
        next_q.mon_load = 1'b0;
        next_q.act_load = 1'b0;
        next_q.gear_push = 1'b0;
        next_q.regif_write_enable = 1'b0;
        next_q.regif_write_data = 16'h0000;
        unique case (q.st)
            aptr_pkg::ST_WAIT_RDY:
            begin
                if (delay_ready)
                begin
                    next_q.st = aptr_pkg::ST_READ;
                    next_q.regif_address = aptr_pkg::BIT_TIME_ADDR; // R12
                    next_q.regif_nibble_select = aptr_pkg::BIT_TIME_NIBBLE; // R14
                    next_q.wait_cnt = 8'h00;
                end
            end
            aptr_pkg::ST_READ:
            begin
                if (rd_valid)
                begin
                    // one count is kept for every channel at this rate
                    next_q.bit_time_taps = rd_data[8:0]; // R4 R16
                    next_q.st = aptr_pkg::ST_LOAD;
                end
                else if (q.wait_cnt == 8'(READ_WAIT_MAX - 1))
                    next_q.st = aptr_pkg::ST_WAIT_RDY;
                else
                    next_q.wait_cnt = 8'(q.wait_cnt + 8'h01);
            end
            aptr_pkg::ST_LOAD:
            begin
                // monitor starts at zero, active half a bit earlier
                next_q.mon_delay = aptr_pkg::TAP_RESET; // R1
                next_q.act_delay = aptr_centre(aptr_pkg::TAP_RESET, q.bit_time_taps); // R3
                next_q.mon_load = 1'b1; // R5
                next_q.act_load = 1'b1; // R5
                next_q.vote = 8'sd0;
                next_q.st = aptr_pkg::ST_TRACK;
            end
            aptr_pkg::ST_TRACK:
            begin
                // every word-rate cycle feeds active bits to the gearbox: four, or three or five on a slip
                next_q.gear_push = 1'b1; // R9
                next_q.gear_nbits = aptr_pkg::PUSH_NORMAL; // R10
                next_q.gear_bits = {1'b0, active_bits};
                next_q.vote = vote_sum;
                if (!delay_ready)
                    next_q.vote = q.vote; // R17
                else if (vote_sum >= 8'(VOTE_LIMIT))
                begin
                    // larger delay moves sampling earlier
                    next_q.vote = 8'sd0;
                    if (q.mon_delay >= 9'(q.bit_time_taps - 9'h001))
                    begin
                        // a whole bit passed: restart the window, drop a bit
                        next_q.mon_delay = aptr_pkg::TAP_RESET;
                        next_q.gear_nbits = aptr_pkg::PUSH_DROP; // R7 R8
                        next_q.gear_bits = {2'b00, active_bits[3:1]};
                    end
                    else
                        next_q.mon_delay = 9'(q.mon_delay + 9'h001); // R2 R5
                    next_q.mon_load = 1'b1;
                    next_q.act_load = 1'b1;
                end
                else if (vote_sum <= -8'(VOTE_LIMIT))
                begin
                    next_q.vote = 8'sd0;
                    if (q.mon_delay == aptr_pkg::TAP_RESET)
                    begin
                        // window slid a whole bit late: insert oversampled bit
                        next_q.mon_delay = 9'(q.bit_time_taps - 9'h001);
                        next_q.gear_nbits = aptr_pkg::PUSH_INSERT; // R7 R8
                        next_q.gear_bits = {active_bits, monitor_bits[0]};
                    end
                    else
                        next_q.mon_delay = 9'(q.mon_delay - 9'h001); // R2 R5
                    next_q.mon_load = 1'b1;
                    next_q.act_load = 1'b1;
                end
                next_q.act_delay = aptr_centre(next_q.mon_delay, q.bit_time_taps); // R3
            end
        endcase
        next_q.tracking = (next_q.st == aptr_pkg::ST_TRACK);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
            q.st <= aptr_pkg::ST_WAIT_RDY;
        end
        else
            q <= next_q;
    end

    // =====================================================================
    // outputs and gearbox
    // =====================================================================
    assign active_load = q.act_load;
    assign active_delay = q.act_delay;
    assign monitor_load = q.mon_load;
    assign monitor_delay = q.mon_delay;
    assign regif_address = q.regif_address;
    assign regif_write_data = q.regif_write_data;
    assign regif_write_enable = q.regif_write_enable;
    assign regif_nibble_select = q.regif_nibble_select;
    assign bit_time_taps = q.bit_time_taps;
    assign tracking = q.tracking;
    assign gear.push = q.gear_push;
    assign gear.nbits = q.gear_nbits;
    assign gear.bits = q.gear_bits;

    aptr_gearbox u_gearbox
    (
        .mclk (mclk),
        .reset (reset),
        .gear (gear),
        .word_data (word_data),
        .word_valid (word_valid),
        .word_ready (word_ready),
        .overflow (gear_overflow)
    );

    // =====================================================================
    // checks
    // =====================================================================
    property p_no_early_adjust;
        @(posedge mclk) disable iff (reset)
        q.mon_load |-> ($past(q.st) == aptr_pkg::ST_LOAD
            || ($past(q.st) == aptr_pkg::ST_TRACK && $past(delay_ready)));
    endproperty
    a_no_early_adjust: assert property (p_no_early_adjust) else $error("delay load before ready"); // R17

    property p_centre_offset;
        @(posedge mclk) disable iff (reset)
        (q.st == aptr_pkg::ST_TRACK) |-> (q.act_delay == 9'(q.mon_delay + {1'b0, q.bit_time_taps[8:1]}));
    endproperty
    a_centre_offset: assert property (p_centre_offset) else $error("active not half a bit off"); // R3

    property p_store_bit_time;
        @(posedge mclk) disable iff (reset)
        (q.st == aptr_pkg::ST_READ && rd_valid) |=> (q.bit_time_taps == $past(rd_data[8:0]));
    endproperty
    a_store_bit_time: assert property (p_store_bit_time) else $error("bit time not stored"); // R4

    property p_read_target;
        @(posedge mclk) disable iff (reset)
        (q.st == aptr_pkg::ST_READ) |-> (q.regif_address == 6'h2c && !q.regif_write_enable);
    endproperty
    a_read_target: assert property (p_read_target) else $error("wrong read address"); // R12

    property p_step_size;
        @(posedge mclk) disable iff (reset)
        ($past(q.st) == aptr_pkg::ST_TRACK && q.mon_load && q.gear_nbits == 3'h4)
            |-> (q.mon_delay == 9'($past(q.mon_delay) + 9'h001)
                || q.mon_delay == 9'($past(q.mon_delay) - 9'h001));
    endproperty
    a_step_size: assert property (p_step_size) else $error("monitor step not one tap"); // R2

    property p_sign_up;
        @(posedge mclk) disable iff (reset)
        (q.st == aptr_pkg::ST_TRACK && delay_ready && vote_sum >= 8'(VOTE_LIMIT)
            && q.mon_delay < 9'(q.bit_time_taps - 9'h001))
            |=> (q.mon_delay == 9'($past(q.mon_delay) + 9'h001));
    endproperty
    a_sign_up: assert property (p_sign_up) else $error("late votes did not raise delay"); // R5

    property p_slip_on_wrap;
        @(posedge mclk) disable iff (reset)
        ($past(q.st) == aptr_pkg::ST_TRACK && q.mon_load && q.mon_delay == 9'h000
            && $past(q.mon_delay) != 9'h001)
            |-> (q.gear_nbits == 3'h3);
    endproperty
    a_slip_on_wrap: assert property (p_slip_on_wrap) else $error("wrap without bit drop"); // R7

    property p_slip_on_unwrap;
        @(posedge mclk) disable iff (reset)
        ($past(q.st) == aptr_pkg::ST_TRACK && q.mon_load && $past(q.mon_delay) == 9'h000
            && q.mon_delay != 9'h001)
            |-> (q.gear_nbits == 3'h5);
    endproperty
    a_slip_on_unwrap: assert property (p_slip_on_unwrap) else $error("unwrap no insert"); // R7

    property p_steady_push;
        @(posedge mclk) disable iff (reset)
        ($past(q.st) == aptr_pkg::ST_TRACK && !q.mon_load) |-> (q.gear_push && q.gear_nbits == 3'h4);
    endproperty
    a_steady_push: assert property (p_steady_push) else $error("tracker push not four bits"); // R10

endmodule : aptr_receiver

// ### aptr_tx_model.sv
// remote transmitter model: bits as seen by the centre and edge slices
`timescale 1ns/10ps
module aptr_tx_model
(
    // stream from the bench, one 4-bit group per word clock
    input wire logic [3:0] send_bits,
    input wire logic lead,
    // slice samples
    output logic [3:0] active_bits,
    output logic [3:0] monitor_bits
);
    // =====================================================================
    // line samples
    // =====================================================================
    // centre slice sees the sent bits, oldest in bit 3, at the word rate
    assign active_bits = send_bits;
    // edge slice lands past the transition when lead is set, before it otherwise
    assign monitor_bits = lead ? ~send_bits : send_bits;
endmodule : aptr_tx_model

// ### aptr_receiver_tb.sv
// self-checking bench of the phase tracking receiver
`timescale 1ns/10ps
module aptr_receiver_tb;
    logic mclk, reset, delay_ready, lead, word_ready, stall;
    logic [3:0] send_bits, active_bits, monitor_bits;
    logic active_load, monitor_load, regif_write_enable, regif_read_valid, regif_read_valid_tx;
    logic [8:0] active_delay, monitor_delay, bit_time_taps, exp_mon;
    logic [5:0] regif_address;
    logic [1:0] regif_nibble_select;
    logic [15:0] regif_write_data, regif_read_data, regif_read_data_tx, lfsr;
    logic tracking, gear_overflow, word_valid, up, check_words, aligned, wrapped;
    logic [9:0] word_data, exp_word;
    logic bitq[$];
    int mismatches, samples_checked, cycles, nloads;

    // =====================================================================
    // design and far side
    // =====================================================================
    aptr_receiver #(.VOTE_LIMIT(4), .READ_WAIT_MAX(4)) u_aptr_receiver (
        .mclk(mclk), .reset(reset), .active_bits(active_bits), .monitor_bits(monitor_bits),
        .delay_ready(delay_ready), .active_load(active_load), .active_delay(active_delay),
        .monitor_load(monitor_load), .monitor_delay(monitor_delay),
        .regif_address(regif_address), .regif_write_data(regif_write_data),
        .regif_write_enable(regif_write_enable), .regif_nibble_select(regif_nibble_select),
        .regif_read_data(regif_read_data), .regif_read_valid(regif_read_valid),
        .regif_read_data_tx(regif_read_data_tx), .regif_read_valid_tx(regif_read_valid_tx),
        .bit_time_taps(bit_time_taps), .tracking(tracking), .gear_overflow(gear_overflow),
        .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready));
    aptr_tx_model u_aptr_tx_model (.send_bits(send_bits), .lead(lead),
        .active_bits(active_bits), .monitor_bits(monitor_bits));

    // =====================================================================
    // helpers
    // =====================================================================
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // =====================================================================
    // clock, timeout and stimulus
    // =====================================================================
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            $display("MISMATCH t=%0t run did not complete", $time);
            tally_and_finish();
        end
    end

    // random line bits and sink stalls; sent bits are noted in order for the checker
    always @(negedge mclk)
    begin
        lfsr <= lfsr_next(lfsr);
        send_bits <= lfsr[3:0];
        word_ready <= !stall && (lfsr[7] | lfsr[9] | !word_ready);
        if (check_words && bit_time_taps !== 9'h000)
            for (int i = 3; i >= 0; i--)
                bitq.push_back(lfsr[i]);
    end

    // =====================================================================
    // output watcher
    // =====================================================================
    always @(posedge mclk)
    begin
        if (!reset && word_valid && word_ready && check_words)
        begin
            // the first word fixes where the stream starts in the note queue
            repeat (40)
                if (!aligned && bitq.size() > 10)
                begin
                    for (int i = 0; i < 10; i++)
                        exp_word[9 - i] = bitq[i];
                    if (exp_word === word_data)
                        aligned = 1'b1;
                    else
                        void'(bitq.pop_front());
                end
            for (int i = 0; i < 10; i++)
                exp_word[9 - i] = bitq.pop_front();
            chk_word(word_data, exp_word);
        end
        if (!reset && (active_load || monitor_load))
        begin
            nloads++;
            // first load sets the start position, later ones are single steps
            if (nloads > 1 && up)
                exp_mon = (exp_mon == 9'h09f) ? 9'h000 : exp_mon + 9'h001;
            else if (nloads > 1)
            begin
                wrapped = wrapped | (exp_mon == 9'h000);
                exp_mon = (exp_mon == 9'h000) ? 9'h09f : exp_mon - 9'h001;
            end
            chk_val({15'h0000, active_load & monitor_load}, 16'h0001, "load pair");
            chk_val({7'h00, monitor_delay}, {7'h00, exp_mon}, "monitor delay");
            chk_val({7'h00, active_delay}, {7'h00, exp_mon + 9'h050}, "active delay");
        end
    end

    // =====================================================================
    // main sequence
    // =====================================================================
    initial
    begin
        reset = 1'b1;
        {delay_ready, lead, stall, word_ready, check_words, aligned, wrapped} = 7'h00;
        send_bits = 4'h0;
        lfsr = 16'h0004;
        {regif_read_valid, regif_read_valid_tx} = 2'h0;
        regif_read_data = 16'h0000;
        regif_read_data_tx = 16'h0000;
        {mismatches, samples_checked, cycles, nloads} = 128'h0;
        exp_mon = 9'h000;
        up = 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk_val({14'h0000, tracking, word_valid}, 16'h0000, "reset outputs");
        reset = 1'b0;
        repeat (8) @(negedge mclk);
        chk_val({10'h000, regif_address}, 16'h0000, "read before ready");
        // start a read, then let it time out unanswered
        delay_ready = 1'b1;
        repeat (10)
            if (regif_address !== 6'h2c)
                @(negedge mclk);
        delay_ready = 1'b0;
        chk_val({10'h000, regif_address}, 16'h002c, "read address");
        chk_val({14'h0000, regif_nibble_select}, 16'h0000, "nibble");
        chk_val({15'h0000, regif_write_enable}, 16'h0000, "write enable");
        chk_val(regif_write_data, 16'h0000, "write data");
        repeat (12) @(negedge mclk);
        chk_val({7'h00, bit_time_taps}, 16'h0000, "taps without answer");
        chk_val({15'h0000, tracking}, 16'h0000, "tracking without answer");
        // retry; answer split over both controllers, first valid lands outside the read
        check_words = 1'b1;
        delay_ready = 1'b1;
        regif_read_data = 16'hfe80;
        regif_read_valid = 1'b1;
        @(negedge mclk);
        {delay_ready, regif_read_valid, regif_read_valid_tx} = 3'h1;
        regif_read_data_tx = 16'h0020;
        @(negedge mclk);
        regif_read_valid_tx = 1'b0;
        repeat (4) @(negedge mclk);
        chk_val({7'h00, bit_time_taps}, 16'h00a0, "stored taps");
        chk_val({15'h0000, tracking}, 16'h0001, "tracking");
        // frozen tracking: words stream through random stalls, no delay steps
        repeat (150) @(negedge mclk);
        check_words = 1'b0;
        chk_val(16'(nloads), 16'h0001, "no steps while not ready");
        chk_val({15'h0000, gear_overflow}, 16'h0000, "no overflow");
        // monitor past the edge: delay steps up
        up = 1'b1;
        lead = 1'b1;
        delay_ready = 1'b1;
        repeat (40) @(negedge mclk);
        delay_ready = 1'b0;
        repeat (3) @(negedge mclk);
        // monitor before the edge: steps down across zero
        up = 1'b0;
        lead = 1'b0;
        delay_ready = 1'b1;
        repeat (80) @(negedge mclk);
        chk_val({15'h0000, wrapped}, 16'h0001, "delay wrapped");
        chk_val({15'h0000, nloads > 20}, 16'h0001, "steps taken");
        // sink stalls until the gearbox refuses
        stall = 1'b1;
        repeat (14) @(negedge mclk);
        chk_val({14'h0000, gear_overflow, word_valid}, 16'h0003, "overflow");
        stall = 1'b0;
        repeat (10) @(negedge mclk);
        chk_val({15'h0000, gear_overflow}, 16'h0001, "overflow sticky");
        // second reset clears everything
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        chk_val({13'h0000, gear_overflow, tracking, active_load}, 16'h0000, "mid reset");
        tally_and_finish();
    end
endmodule : aptr_receiver_tb
